// ---- hdl/tsc_defs.svh ----
/*
  register offsets, field positions, reset values and timing figures
  of the sensor control block.
  assumes: included by bare name by the design file.
*/
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TSC_OFS_GAIN_DRIVE   8'hb9
`define TSC_OFS_TEMP_HIGH    8'hd1
`define TSC_OFS_TEMP_LOW     8'hd2
`define TSC_OFS_TEMP_CTRL    8'hd3
`define TSC_OFS_INTEG_TIME   8'hd9
`define TSC_OFS_WAIT_TIME    8'hda
`define TSC_OFS_CHAN_SET     8'hdb
`define TSC_OFS_NIR_LOW      8'hdc
`define TSC_OFS_NIR_HIGH     8'hdd
`define TSC_OFS_Y_LOW        8'hde
`define TSC_OFS_Y_HIGH       8'hdf
`define TSC_OFS_LED_DRIVER   8'hea
`define TSC_OFS_Z_LOW        8'hec
`define TSC_OFS_Z_HIGH       8'hed
`define TSC_OFS_X_LOW        8'hee
`define TSC_OFS_X_HIGH       8'hef
`define TSC_OFS_ACQ_CTRL     8'hfa

// ****************************************************************
// field positions
// ****************************************************************
`define TSC_BIT_DONE_FLAG    7
`define TSC_BIT_TEMP_START   5
`define TSC_SOURCE_START     4'h4
`define TSC_BIT_CHAN_SET     7
`define TSC_BIT_LED_ON       2
`define TSC_BIT_LATCH        7
`define TSC_BIT_WAIT_EN      3
`define TSC_BIT_ACQ_EN       1

// ****************************************************************
// reset values
// ****************************************************************
`define TSC_RST_GAIN_DRIVE   8'h00
`define TSC_RST_TIME         8'hff
`define TSC_RST_CTRL         8'h00

// ****************************************************************
// timing: one time unit and the clock period, both in ns
// ****************************************************************
`define TSC_UNIT_NS          2800000
`define TSC_CLK_NS           100
`define TSC_UNIT_CYCLES      (`TSC_UNIT_NS / `TSC_CLK_NS)
`define TSC_UNIT_COUNT       9'h100

`endif

// ---- hdl/tsc_pkg.sv ----
/*
  types shared by the sensor control block.
  assumes: nothing beyond the defs header.
*/
package tsc_pkg;

  // acquisition sequencer states
  typedef enum logic [1:0] {
    TSC_ACQ_IDLE,
    TSC_ACQ_INTEG,
    TSC_ACQ_WAIT
  } tsc_acq_state_t;

endpackage : tsc_pkg

// ---- hdl/tsc_sensor_ctrl.sv ----
/*
  register file, temperature conversion control and channel acquisition
  sequencer of a colour and near-infrared sensor.
  assumes: a serial slave front end outside turns bus traffic into
  single-cycle read and write strobes with an 8-bit offset; the analog
  side answers a conversion request with a done pulse and result, and
  presents channel counts that are valid when integration ends.
*/
// Summary of operation
// - temperature high register holds result bits 9:2
// - temperature low register holds result bits 1:0
// - done flag sets on conversion end; writes clear
// - start bit one starts conversion, zero idles unless source is 0100
// - source field 0100 starts, 0000 idles conversion unless start bit is set
// - channel set bit picks readout channel bank
// - bits 7:6 pick led driver current limit
// - bits 1:0 pick one gain for all channels
// - integration lasts (256 minus value) times 2.8 ms
// - wait lasts (256 minus value) times 2.8 ms
// - wait timer used only while wait enabled
// - acquisitions run only while acquisition enabled
// - latch bit holds results after acquisition completes
// - infrared and y result byte pairs, read only
// - z and x result byte pairs, read only
// - led driver pin on at limit while bit set
`include "tsc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module tsc_sensor_ctrl #(
  parameter int unsigned UNIT_CYCLES = `TSC_UNIT_CYCLES  // cycles per 2.8 ms
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        temp_done,
  input  wire logic [9:0]  temp_result,
  input  wire logic [15:0] sample_x,
  input  wire logic [15:0] sample_y,
  input  wire logic [15:0] sample_z,
  input  wire logic [15:0] sample_n,
  output logic             temp_convert,
  output logic             integrating,
  output logic             channel_set,
  output logic [1:0]       channel_gain,
  output logic [1:0]       drive_current_limit,
  output logic             led_driver_pin
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************

  // write strobe aimed at one offset
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = reg_write && (reg_addr == ofs);
  endfunction : wr_hit

  // span of a timed phase in time units
  function automatic logic [8:0] span(input logic [7:0] value);
    span = `TSC_UNIT_COUNT - {1'b0, value};
  endfunction : span

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0]  gain_drive_reg;     // limit, gain
  logic [7:0]  integ_time_reg;     // integration length
  logic [7:0]  wait_time_reg;      // wait length
  logic [7:0]  chan_set_reg;       // bank select
  logic [7:0]  led_ctrl_reg;       // driver on/off
  logic [7:0]  acq_ctrl_reg;       // latch, wait, enable, power
  logic [7:0]  gain_drive_next;
  logic [7:0]  integ_time_next;
  logic [7:0]  wait_time_next;
  logic [7:0]  chan_set_next;
  logic [7:0]  led_ctrl_next;
  logic [7:0]  acq_ctrl_next;

  // plain storage; reserved bits are kept as written
  always_comb begin
    gain_drive_next = gain_drive_reg;
    integ_time_next = integ_time_reg;
    wait_time_next  = wait_time_reg;
    chan_set_next   = chan_set_reg;
    led_ctrl_next   = led_ctrl_reg;
    acq_ctrl_next   = acq_ctrl_reg;
    if (wr_hit(`TSC_OFS_GAIN_DRIVE)) begin
      gain_drive_next = reg_wdata;
    end
    if (wr_hit(`TSC_OFS_INTEG_TIME)) begin
      integ_time_next = reg_wdata;
    end
    if (wr_hit(`TSC_OFS_WAIT_TIME)) begin
      wait_time_next = reg_wdata;
    end
    if (wr_hit(`TSC_OFS_CHAN_SET)) begin
      chan_set_next = reg_wdata;
    end
    if (wr_hit(`TSC_OFS_LED_DRIVER)) begin
      led_ctrl_next = reg_wdata;
    end
    if (wr_hit(`TSC_OFS_ACQ_CTRL)) begin
      acq_ctrl_next = reg_wdata;
    end
  end

  // registers only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gain_drive_reg <= `TSC_RST_GAIN_DRIVE;
      integ_time_reg <= `TSC_RST_TIME;
      wait_time_reg  <= `TSC_RST_TIME;
      chan_set_reg   <= `TSC_RST_CTRL;
      led_ctrl_reg   <= `TSC_RST_CTRL;
      acq_ctrl_reg   <= `TSC_RST_CTRL;
    end else begin
      gain_drive_reg <= gain_drive_next;
      integ_time_reg <= integ_time_next;
      wait_time_reg  <= wait_time_next;
      chan_set_reg   <= chan_set_next;
      led_ctrl_reg   <= led_ctrl_next;
      acq_ctrl_reg   <= acq_ctrl_next;
    end
  end

  // ****************************************************************
  // temperature conversion
  // ****************************************************************
  logic       temp_busy_reg;       // conversion running
  logic       done_flag_reg;       // sticky completion
  logic [9:0] temp_value_reg;      // last finished result
  logic       temp_busy_next;
  logic       done_flag_next;
  logic [9:0] temp_value_next;
  logic       temp_req;            // this write asks for a conversion

  // a write with start bit or source 0100 starts, else idles
  always_comb begin
    temp_req = reg_wdata[`TSC_BIT_TEMP_START] ||
               (reg_wdata[3:0] == `TSC_SOURCE_START);
    temp_busy_next  = temp_busy_reg;
    done_flag_next  = done_flag_reg;
    temp_value_next = temp_value_reg;
    if (wr_hit(`TSC_OFS_TEMP_CTRL)) begin
      temp_busy_next = temp_req;
      done_flag_next = 1'b0;
    end else if (temp_done && temp_busy_reg) begin
      temp_busy_next = 1'b0;
    end
    // completion wins over a clearing write in the same cycle
    if (temp_done && temp_busy_reg) begin
      done_flag_next  = 1'b1;
      temp_value_next = temp_result;
    end
  end

  // registers only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      temp_busy_reg  <= 1'b0;
      done_flag_reg  <= 1'b0;
      temp_value_reg <= 10'h000;
    end else begin
      temp_busy_reg  <= temp_busy_next;
      done_flag_reg  <= done_flag_next;
      temp_value_reg <= temp_value_next;
    end
  end

  // ****************************************************************
  // acquisition sequencer
  // ****************************************************************
  tsc_pkg::tsc_acq_state_t acq_state_reg;   // phase
  tsc_pkg::tsc_acq_state_t acq_state_next;
  logic [31:0] tick_reg;           // cycles left in this unit
  logic [8:0]  units_reg;          // units left in this phase
  logic        held_reg;           // results frozen by latch bit
  logic [31:0] tick_next;
  logic [8:0]  units_next;
  logic        held_next;
  logic        phase_end;          // last cycle of a phase
  logic        capture;            // load channel results

  // integrate, optionally wait, repeat while enabled
  always_comb begin
    acq_state_next = acq_state_reg;
    tick_next      = tick_reg;
    units_next     = units_reg;
    held_next      = held_reg;
    capture        = 1'b0;
    phase_end      = (tick_reg == 32'h0) && (units_reg == 9'h001);
    if (tick_reg != 32'h0) begin
      tick_next = tick_reg - 32'h1;
    end else begin
      tick_next  = UNIT_CYCLES - 32'h1;
      units_next = units_reg - 9'h001;
    end
    // rewriting the control register releases frozen results; an integration end in the same cycle wins
    if (wr_hit(`TSC_OFS_ACQ_CTRL)) begin
      held_next = 1'b0;
    end
    unique case (acq_state_reg)
      tsc_pkg::TSC_ACQ_IDLE: begin
        tick_next  = UNIT_CYCLES - 32'h1;
        units_next = span(integ_time_reg);
        if (acq_ctrl_reg[`TSC_BIT_ACQ_EN]) begin
          acq_state_next = tsc_pkg::TSC_ACQ_INTEG;
        end
      end
      tsc_pkg::TSC_ACQ_INTEG: begin
        if (phase_end) begin
          capture   = !held_reg;
          held_next = held_reg || acq_ctrl_reg[`TSC_BIT_LATCH];
          tick_next = UNIT_CYCLES - 32'h1;
          if (acq_ctrl_reg[`TSC_BIT_WAIT_EN]) begin
            acq_state_next = tsc_pkg::TSC_ACQ_WAIT;
            units_next     = span(wait_time_reg);
          end else begin
            units_next = span(integ_time_reg);
          end
        end
      end
      tsc_pkg::TSC_ACQ_WAIT: begin
        if (phase_end) begin
          acq_state_next = tsc_pkg::TSC_ACQ_INTEG;
          tick_next      = UNIT_CYCLES - 32'h1;
          units_next     = span(integ_time_reg);
        end
      end
    endcase
    if (!acq_ctrl_reg[`TSC_BIT_ACQ_EN]) begin
      acq_state_next = tsc_pkg::TSC_ACQ_IDLE;
    end
  end

  // registers only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acq_state_reg <= tsc_pkg::TSC_ACQ_IDLE;
      tick_reg      <= 32'h0;
      units_reg     <= 9'h001;
      held_reg      <= 1'b0;
    end else begin
      acq_state_reg <= acq_state_next;
      tick_reg      <= tick_next;
      units_reg     <= units_next;
      held_reg      <= held_next;
    end
  end

  // ****************************************************************
  // channel results and readout
  // ****************************************************************
  logic [15:0] chan_reg [4];       // x, y, z, n
  logic [15:0] chan_next [4];
  logic [7:0]  high_shadow_reg [4]; // high byte snapped at low read
  logic [7:0]  high_shadow_next [4];
  logic [15:0] chan_in [4];
  logic [7:0]  rdata_next;

  assign chan_in[0] = sample_x;
  assign chan_in[1] = sample_y;
  assign chan_in[2] = sample_z;
  assign chan_in[3] = sample_n;

  // low-byte offset of channel c read in this cycle
  function automatic logic reg_read_low(input int c);
    logic [7:0] ofs;
    ofs = (c == 0) ? `TSC_OFS_X_LOW : (c == 1) ? `TSC_OFS_Y_LOW :
          (c == 2) ? `TSC_OFS_Z_LOW : `TSC_OFS_NIR_LOW;
    reg_read_low = reg_read && (reg_addr == ofs);
  endfunction : reg_read_low

  // results load together; low read freezes its partner high byte
  for (genvar c = 0; c < 4; c++) begin : g_chan
    always_comb begin
      chan_next[c]        = capture ? chan_in[c] : chan_reg[c];
      high_shadow_next[c] = reg_read_low(c) ? chan_reg[c][15:8]
                                            : high_shadow_reg[c];
    end
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        chan_reg[c]        <= 16'h0000;
        high_shadow_reg[c] <= 8'h00;
      end else begin
        chan_reg[c]        <= chan_next[c];
        high_shadow_reg[c] <= high_shadow_next[c];
      end
    end
  end

  // read multiplexer; unmapped offsets answer zero
  always_comb begin
    rdata_next = reg_rdata;
    if (reg_read) begin
      unique case (reg_addr)
        `TSC_OFS_GAIN_DRIVE: rdata_next = gain_drive_reg;
        `TSC_OFS_TEMP_HIGH:  rdata_next = temp_value_reg[9:2];
        `TSC_OFS_TEMP_LOW:   rdata_next = {6'h00, temp_value_reg[1:0]};
        `TSC_OFS_TEMP_CTRL:  rdata_next = {done_flag_reg, 1'b0,
                                           temp_busy_reg, 1'b0,
                                           temp_busy_reg ? `TSC_SOURCE_START :
                                           4'h0};
        `TSC_OFS_INTEG_TIME: rdata_next = integ_time_reg;
        `TSC_OFS_WAIT_TIME:  rdata_next = wait_time_reg;
        `TSC_OFS_CHAN_SET:   rdata_next = chan_set_reg;
        `TSC_OFS_LED_DRIVER: rdata_next = led_ctrl_reg;
        `TSC_OFS_ACQ_CTRL:   rdata_next = acq_ctrl_reg;
        `TSC_OFS_NIR_LOW:    rdata_next = chan_reg[3][7:0];
        `TSC_OFS_NIR_HIGH:   rdata_next = high_shadow_reg[3];
        `TSC_OFS_Y_LOW:      rdata_next = chan_reg[1][7:0];
        `TSC_OFS_Y_HIGH:     rdata_next = high_shadow_reg[1];
        `TSC_OFS_Z_LOW:      rdata_next = chan_reg[2][7:0];
        `TSC_OFS_Z_HIGH:     rdata_next = high_shadow_reg[2];
        `TSC_OFS_X_LOW:      rdata_next = chan_reg[0][7:0];
        `TSC_OFS_X_HIGH:     rdata_next = high_shadow_reg[0];
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // outputs, all registered
  // ****************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata           <= 8'h00;
      temp_convert        <= 1'b0;
      integrating         <= 1'b0;
      channel_set         <= 1'b0;
      channel_gain        <= 2'b00;
      drive_current_limit <= 2'b00;
      led_driver_pin      <= 1'b0;
    end else begin
      reg_rdata           <= rdata_next;
      temp_convert        <= temp_busy_next;
      integrating         <= acq_state_next == tsc_pkg::TSC_ACQ_INTEG;
      channel_set         <= chan_set_next[`TSC_BIT_CHAN_SET];
      channel_gain        <= gain_drive_next[1:0];
      drive_current_limit <= gain_drive_next[7:6];
      led_driver_pin      <= led_ctrl_next[`TSC_BIT_LED_ON];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_done_seen;
    temp_done && temp_busy_reg;
  endsequence
  property p_done_sets;
    @(posedge clock) disable iff (!reset_n)
      s_done_seen |=> done_flag_reg;
  endproperty
  a_done_sets: assert property (p_done_sets)
    else $error("done flag not set after conversion end");

  property p_result_high;
    @(posedge clock) disable iff (!reset_n)
      s_done_seen ##1 (reg_read && reg_addr == `TSC_OFS_TEMP_HIGH)
      |=> reg_rdata == $past(temp_result, 2) >> 2;
  endproperty
  a_result_high: assert property (p_result_high)
    else $error("temperature high byte wrong");

  property p_result_hold;
    @(posedge clock) disable iff (!reset_n)
      !(temp_done && temp_busy_reg) |=> $stable(temp_value_reg);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("temperature result changed without conversion");

  property p_start;
    @(posedge clock) disable iff (!reset_n)
      wr_hit(`TSC_OFS_TEMP_CTRL) && reg_wdata[3:0] == `TSC_SOURCE_START
      |=> temp_convert;
  endproperty
  a_start: assert property (p_start)
    else $error("conversion not started by source field");

  property p_idle_write;
    @(posedge clock) disable iff (!reset_n)
      wr_hit(`TSC_OFS_TEMP_CTRL) && !temp_req |=> !temp_convert;
  endproperty
  a_idle_write: assert property (p_idle_write)
    else $error("conversion not idled by zero write");

  property p_no_acq;
    @(posedge clock) disable iff (!reset_n)
      !acq_ctrl_reg[`TSC_BIT_ACQ_EN] |=> !integrating;
  endproperty
  a_no_acq: assert property (p_no_acq)
    else $error("integrating while acquisitions disabled");

  property p_no_wait;
    @(posedge clock) disable iff (!reset_n)
      acq_state_reg == tsc_pkg::TSC_ACQ_INTEG && phase_end &&
      !acq_ctrl_reg[`TSC_BIT_WAIT_EN] && acq_ctrl_reg[`TSC_BIT_ACQ_EN]
      |=> integrating;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("wait applied while wait timer disabled");

  property p_held;
    @(posedge clock) disable iff (!reset_n)
      held_reg && !wr_hit(`TSC_OFS_ACQ_CTRL) |=> $stable(chan_reg[0]);
  endproperty
  a_held: assert property (p_held)
    else $error("latched results changed");

  property p_led;
    @(posedge clock) disable iff (!reset_n)
      wr_hit(`TSC_OFS_LED_DRIVER) |=>
      led_driver_pin == $past(reg_wdata[`TSC_BIT_LED_ON]);
  endproperty
  a_led: assert property (p_led)
    else $error("led driver pin does not follow its bit");

endmodule : tsc_sensor_ctrl

`default_nettype wire

// ---- test/tsc_host_model.sv ----
/*
  host side model of the sensor block's register strobe port.
  assumes: the block samples its strobes on the rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// host register access
// ****************************************************************
module tsc_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_write,
  output var  logic       reg_read
);
  // idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end
  // one write strobe; reserved bits always go out as zero
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    case (addr)
      8'hb9:   d = data & 8'hc3;
      8'hd3:   d = data & 8'h2f;
      8'hdb:   d = data & 8'h80;
      8'hea:   d = data & 8'h04;
      8'hfa:   d = (data & 8'h8a) | 8'h01;
      default: d = data;
    endcase
    @(posedge clock);
    reg_addr  <= addr;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // released data lines do not keep the last value
    reg_wdata <= ~d;
  endtask : write_reg
  // one read strobe; the registered answer is taken once settled
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clock);
    reg_addr <= addr;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_addr <= ~addr;
    #1 data = reg_rdata;
  endtask : read_reg
endmodule : tsc_host_model
`default_nettype wire

// ---- test/tristimulus_sensor_control_regs_test.sv ----
/*
  self-checking bench of the sensor control block.
  assumes: host model drives the register port; analog side is here.
*/
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// bench
// ****************************************************************
module tristimulus_sensor_control_regs_test;
  // access row: write data, or expected read data
  typedef struct {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } tsc_row_t;
  logic        clock       = 1'b0;
  logic        reset_n     = 1'b0;
  logic        temp_done   = 1'b0;
  logic [9:0]  temp_result = 10'h000;
  logic [15:0] sample_x    = 16'h1234;
  logic [15:0] sample_y    = 16'h5678;
  logic [15:0] sample_z    = 16'h9abc;
  logic [15:0] sample_n    = 16'hdef0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
  logic        reg_write, reg_read, temp_convert, integrating;
  logic        channel_set, led_driver_pin;
  logic [1:0]  channel_gain, drive_current_limit;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          n;
  // reset values, refused writes, read back of stored fields
  tsc_row_t rows [18] = '{
    '{1'b0, 8'hb9, 8'h00}, '{1'b0, 8'hd3, 8'h00}, '{1'b0, 8'hd9, 8'hff},
    '{1'b0, 8'hda, 8'hff}, '{1'b0, 8'hdb, 8'h00}, '{1'b0, 8'hfa, 8'h00},
    '{1'b0, 8'h10, 8'h00}, '{1'b1, 8'hd1, 8'h55}, '{1'b0, 8'hd1, 8'h00},
    '{1'b1, 8'hdd, 8'haa}, '{1'b0, 8'hdd, 8'h00}, '{1'b1, 8'hdb, 8'h80},
    '{1'b0, 8'hdb, 8'h80}, '{1'b1, 8'hb9, 8'hc3}, '{1'b0, 8'hb9, 8'hc3},
    '{1'b1, 8'hd9, 8'hfe}, '{1'b1, 8'hda, 8'hfd}, '{1'b0, 8'hda, 8'hfd}
  };
  // short count unit keeps the timed phases to a few cycles
  tsc_sensor_ctrl #(.UNIT_CYCLES(4)) i_dut (
    .clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .temp_done, .temp_result, .sample_x, .sample_y,
    .sample_z, .sample_n, .temp_convert, .integrating, .channel_set,
    .channel_gain, .drive_current_limit, .led_driver_pin
  );
  tsc_host_model i_host (
    .clock, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read
  );
  always #50 clock = ~clock;
  // compare and count; unknowns never match
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host.read_reg(a, rd);
    check(16'(rd), 16'(e));
  endtask : rd_chk
  // low byte first, so the high byte is the matching snapshot
  task automatic pair_chk(input logic [7:0] a, input logic [15:0] e);
    logic [7:0] lo;
    i_host.read_reg(a, lo);
    i_host.read_reg(a + 8'h01, rd);
    check({rd, lo}, e);
  endtask : pair_chk
  task automatic temp_pulse(input logic [9:0] r);
    @(posedge clock);
    temp_done   <= 1'b1;
    temp_result <= r;
    @(posedge clock);
    temp_done   <= 1'b0;
  endtask : temp_pulse
  // cycles spent at level v, after a bounded wait for it
  task automatic run_len(input logic v, output int k);
    k = 0;
    while (integrating !== v && k < 400) begin
      @(posedge clock);
      #1 k++;
    end
    k = 0;
    while (integrating === v && k < 400) begin
      @(posedge clock);
      #1 k++;
    end
  endtask : run_len
  task automatic count_high(input int len, output int h);
    h = 0;
    repeat (len) begin
      @(posedge clock);
      #1 h += int'(integrating === 1'b1);
    end
  endtask : count_high
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) i_host.write_reg(rows[i].addr, rows[i].data);
      else rd_chk(rows[i].addr, rows[i].data);
    end
    #1 check(16'(channel_set), 16'h0001);
    i_host.write_reg(8'hdb, 8'h00);
    #1 check(16'(channel_set), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      i_host.write_reg(8'hb9, {i[1:0], 4'h0, i[1:0]});
      #1 check(16'(drive_current_limit), 16'(i));
      check(16'(channel_gain), 16'(i));
    end
    i_host.write_reg(8'hea, 8'h04);
    #1 check(16'(led_driver_pin), 16'h0001);
    i_host.write_reg(8'hea, 8'h00);
    #1 check(16'(led_driver_pin), 16'h0000);
    i_host.write_reg(8'hd3, 8'h20);
    #1 check(16'(temp_convert), 16'h0001);
    // read the high byte in the cycle right after completion
    fork
      temp_pulse(10'h2d6);
      begin
        @(posedge clock);
        rd_chk(8'hd1, 8'hb5);
      end
    join
    @(posedge clock);
    #1 check(16'(temp_convert), 16'h0000);
    rd_chk(8'hd3, 8'h80);
    rd_chk(8'hd1, 8'hb5);
    rd_chk(8'hd2, 8'h02);
    i_host.write_reg(8'hd3, 8'h04);
    #1 check(16'(temp_convert), 16'h0001);
    rd_chk(8'hd3, 8'h24);
    i_host.write_reg(8'hd3, 8'h00);
    #1 check(16'(temp_convert), 16'h0000);
    temp_pulse(10'h0ff);
    rd_chk(8'hd1, 8'hb5);
    rd_chk(8'hd3, 8'h00);
    i_host.write_reg(8'hfa, 8'h0b);
    run_len(1'b1, n);
    check(16'(n), 16'h0008);
    run_len(1'b0, n);
    check(16'(n), 16'h000c);
    pair_chk(8'hee, 16'h1234);
    pair_chk(8'hec, 16'h9abc);
    pair_chk(8'hdc, 16'hdef0);
    pair_chk(8'hde, 16'h5678);
    i_host.write_reg(8'hfa, 8'h03);
    count_high(40, n);
    check(16'(n > 24), 16'h0001);
    // frozen results must ignore a later change of counts
    i_host.write_reg(8'hfa, 8'h8b);
    run_len(1'b1, n);
    @(posedge clock);
    sample_x <= 16'h4321;
    run_len(1'b1, n);
    run_len(1'b0, n);
    pair_chk(8'hee, 16'h1234);
    i_host.write_reg(8'hfa, 8'h0b);
    run_len(1'b1, n);
    run_len(1'b0, n);
    pair_chk(8'hee, 16'h4321);
    i_host.write_reg(8'hfa, 8'h01);
    repeat (2) @(posedge clock);
    count_high(30, n);
    check(16'(n), 16'h0000);
    // second reset in mid-run
    @(posedge clock);
    reset_n <= 1'b0;
    #1 check({reg_rdata, temp_convert, integrating, channel_set,
              led_driver_pin, channel_gain, drive_current_limit}, 16'h0000);
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rd_chk(8'hd9, 8'hff);
    rd_chk(8'hb9, 8'h00);
    print_verdict();
  end
endmodule : tristimulus_sensor_control_regs_test
`default_nettype wire
